//--- aof_fifo.sv
// Small synchronous FIFO between converter core and output pins.
// Assumes one clock and a synchronous active-high clear.
`timescale 1ns/10ps
module aof_fifo
  import aof_pkg::*;
#(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,       // System clock
  input  wire logic             clear_in,     // Synchronous clear
  input  wire logic [WIDTH-1:0] wr_data_in,   // Write word
  input  wire logic             wr_valid_in,  // Write request
  output logic                  wr_ready_out, // Room available
  output logic      [WIDTH-1:0] rd_data_out,  // Head word
  output logic                  rd_valid_out, // Head valid
  input  wire logic             rd_ready_in   // Reader takes word
);
  localparam int AW = $clog2(DEPTH);
  // Storage and pointers with one extra wrap bit
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr_r;
  logic [AW:0]      rptr_r;
  logic             full_w;
  logic             empty_w;
  logic             push_w;
  logic             pop_w;

  // Honest full and empty from pointer compare
  assign full_w  = (wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
  assign empty_w = (wptr_r == rptr_r);
  assign push_w  = wr_valid_in && !full_w;
  assign pop_w   = rd_ready_in && !empty_w;
  assign wr_ready_out = !full_w;
  assign rd_valid_out = !empty_w;
  assign rd_data_out  = mem[rptr_r[AW-1:0]];

  // Pointer and storage update
  always_ff @(posedge clk_in) begin
    if (clear_in) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      if (push_w) begin
        mem[wptr_r[AW-1:0]] <= wr_data_in;
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop_w) begin
        rptr_r <= rptr_r + 1'b1;
      end
    end
  end
endmodule // aof_fifo

//--- aof_formatter.sv
// Output stage: centring, clamping, flag, format, pins, sync clock.
// Assumes the sample clock and raw core code arrive asynchronously
// and are sampled on clk_in; raw code is stable around its clock edge.
`timescale 1ns/10ps
`include "aof_map.svh"
module aof_formatter
  import aof_pkg::*;
#(
  parameter int DATA_W = `AOF_DATA_W,
  parameter int DEPTH  = `AOF_FIFO_DEPTH
) (
  input  wire logic              clk_in,                 // 200 MHz system clock
  input  wire logic              sys_rst_in,             // Synchronous reset, high
  input  wire logic              clock_in_pos,           // Sample clock, true side
  input  wire logic              clock_in_neg,           // Sample clock, inverted side
  input  wire logic [DATA_W-1:0] raw_code_in,            // Uncorrected core code
  input  wire logic              raw_over_in,            // Core over range
  input  wire logic              raw_under_in,           // Core under range
  input  wire logic [DATA_W-1:0] offset_trim_in,         // Signed offset correction
  input  wire logic              format_select,          // 0 offset binary, 1 twos
  input  wire logic              output_disable_in,      // High tristates data
  input  wire logic              sync_clock_enable_low,  // Low drives sync clock
  input  wire logic              power_down_low,         // Low powers down
  output logic      [DATA_W-1:0] data_out,               // Parallel sample word
  output logic      [DATA_W-1:0] data_oe_out,            // Data pin drive enables
  output logic                   out_of_range_flag,      // Flag pin
  output logic                   flag_oe_out,            // Flag pin drive enable
  output logic                   data_sync_clock_out,    // Companion clock
  output logic                   sync_clock_oe_out,      // Companion clock enable
  output logic                   overflow_out            // FIFO lost a sample
);
  // Whole module state in one struct
  typedef struct packed {
    logic [1:0]        ckp_sync;   // Clock sync chain
    logic [1:0]        ckn_sync;   // Inverted side chain
    logic              ck_prev;    // Last synced clock level
    logic [1:0]        pd_sync;    // Power-down sync chain
    logic [1:0]        oe_sync;    // Output disable chain
    logic [1:0]        ce_sync;    // Sync clock enable chain
    logic [1:0]        fmt_sync;   // Format select chain
    logic [1:0][DATA_W-1:0] raw_sync;  // Raw code sync chain
    logic [1:0][DATA_W-1:0] trim_sync; // Offset trim sync chain
    logic [1:0]        ovr_sync;   // Over range chain
    logic [1:0]        und_sync;   // Under range chain
    logic              ck_edge;    // One-cycle sample pulse
    aof_state_t        state;      // Power state
    logic [DATA_W-1:0] data;       // Output word
    logic              flag;       // Output flag
    logic              sclk;       // Sync clock level
    logic              ovf;        // Overflow sticky
    logic              wfmt;       // Format of the shown word
    logic              doe;        // Data and flag pin enable
    logic              coe;        // Sync clock pin enable
  } aof_st_t;

  aof_st_t st_r;
  aof_st_t st_nxt;

  // FIFO wiring
  logic [DATA_W+1:0] fifo_wdata;   // Format bit, flag, word
  logic              fifo_wready;
  logic [DATA_W+1:0] fifo_rdata;   // Format bit, flag, word
  logic              ck_lvl_w;     // Resolved sample clock level
  logic              fifo_rvalid;
  logic              fifo_clear;

  // Centre, clamp and flag a raw code
  function automatic logic [DATA_W:0] fmt_code(input logic [DATA_W-1:0] raw,
                                               input logic [DATA_W-1:0] trim,
                                               input logic ovr, input logic und);
    logic [DATA_W+1:0] sum;
    logic [DATA_W-1:0] code;
    logic              fl;
    sum  = {2'b00, raw} + {{2{trim[DATA_W-1]}}, trim};  // RL3
    code = sum[DATA_W-1:0];
    fl   = 1'b0;
    // Clip before extreme code; flag on clip
    if (ovr || (!sum[DATA_W+1] && (sum[DATA_W] || (code >= `AOF_CLIP_HI)))) begin // RL5
      code = `AOF_ALL_ONES;                              // RL4
      fl   = 1'b1;                                       // RL11
    end else if (und || sum[DATA_W+1] || (code <= `AOF_CLIP_LO)) begin
      code = `AOF_ALL_ZEROS;                             // RL4
      fl   = 1'b1;                                       // RL11
    end
    return {fl, code};
  endfunction

  // Format bit travels with the word so it matches its own sample
  assign fifo_wdata = {st_r.fmt_sync[1],
                       fmt_code(st_r.raw_sync[1], st_r.trim_sync[1],
                                st_r.ovr_sync[1], st_r.und_sync[1])};     // RL8
  // Differential level; CMOS use grounds the inverted side
  assign ck_lvl_w   = st_r.ckp_sync[1] && !st_r.ckn_sync[1];
  assign fifo_clear = sys_rst_in || (st_r.state == AOF_ST_OFF);

  // Buffer between capture and output pins
  aof_fifo #(
    .WIDTH (DATA_W + 2),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_in       (clk_in),
    .clear_in     (fifo_clear),
    .wr_data_in   (fifo_wdata),
    .wr_valid_in  (st_r.ck_edge),
    .wr_ready_out (fifo_wready),
    .rd_data_out  (fifo_rdata),
    .rd_valid_out (fifo_rvalid),
    .rd_ready_in  (st_r.ck_edge)
  );

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.ckp_sync = {st_r.ckp_sync[0], clock_in_pos};
    st_nxt.ckn_sync = {st_r.ckn_sync[0], clock_in_neg};
    st_nxt.pd_sync  = {st_r.pd_sync[0], power_down_low};
    st_nxt.oe_sync  = {st_r.oe_sync[0], output_disable_in};
    st_nxt.ce_sync  = {st_r.ce_sync[0], sync_clock_enable_low};
    st_nxt.fmt_sync = {st_r.fmt_sync[0], format_select};
    st_nxt.raw_sync  = {st_r.raw_sync[0], raw_code_in};
    st_nxt.trim_sync = {st_r.trim_sync[0], offset_trim_in};
    st_nxt.ovr_sync  = {st_r.ovr_sync[0], raw_over_in};
    st_nxt.und_sync  = {st_r.und_sync[0], raw_under_in};
    // Pin enables registered so every pin leaves a flip-flop
    st_nxt.doe      = !st_r.oe_sync[1];                            // RL2
    st_nxt.coe      = !st_r.ce_sync[1];                            // RL9
    st_nxt.ck_prev  = ck_lvl_w;
    // Rising edge only; the falling edge never samples
    st_nxt.ck_edge  = ck_lvl_w && !st_r.ck_prev;                   // RL1
    st_nxt.ovf      = st_r.ovf || (st_r.ck_edge && !fifo_wready);
    case (st_r.state)
      AOF_ST_OFF: begin
        st_nxt.data = '0;                                          // RL10
        st_nxt.flag = 1'b0;                                        // RL10
        st_nxt.sclk = 1'b0;                                        // RL10
        st_nxt.ovf  = 1'b0;
        if (st_r.pd_sync[1]) begin
          st_nxt.state = AOF_ST_RUN;
        end
      end
      AOF_ST_RUN: begin
        if (!st_r.pd_sync[1]) begin
          st_nxt.state = AOF_ST_OFF;
          st_nxt.data  = '0;                                       // RL10
          st_nxt.flag  = 1'b0;
          st_nxt.sclk  = 1'b0;
        end else begin
          // Sync clock follows input; word moves one cycle after its rise
          st_nxt.sclk = ck_lvl_w;
          if (st_r.ck_edge && fifo_rvalid) begin
            // Word and flag move together
            st_nxt.flag = fifo_rdata[DATA_W];                      // RL12
            st_nxt.wfmt = fifo_rdata[DATA_W+1];
            // Twos complement inverts the MSB only
            st_nxt.data = fifo_rdata[DATA_W-1:0] ^
                          {fifo_rdata[DATA_W+1], {(DATA_W-1){1'b0}}};  // RL8
          end
        end
      end
      default: begin
        st_nxt.state = AOF_ST_OFF;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Pin drivers from registers
  assign data_out            = st_r.data;
  assign data_oe_out         = {DATA_W{st_r.doe}};                 // RL2
  assign flag_oe_out         = st_r.doe;                           // RL2
  assign out_of_range_flag   = st_r.flag;                          // RL6
  assign data_sync_clock_out = st_r.sclk;
  assign sync_clock_oe_out   = st_r.coe;                           // RL9
  assign overflow_out        = st_r.ovf;

  // Freshly loaded offset binary word: flag exactly on all ones or zeros
  property p_flag_extreme;
    @(posedge clk_in) disable iff (sys_rst_in)
    ($past(st_r.ck_edge) && $past(fifo_rvalid) && $past(st_r.pd_sync[1]) &&
     $past(st_r.state) == AOF_ST_RUN && !st_r.wfmt) |->
      (st_r.flag == ((st_r.data == `AOF_ALL_ONES) || (st_r.data == `AOF_ALL_ZEROS)));
  endproperty
  a_flag_extreme: assert property (p_flag_extreme) else $error("flag vs word mismatch"); // RL6
  // Flag rises only with an extreme offset binary word
  property p_flag_word;
    @(posedge clk_in) disable iff (sys_rst_in)
    (st_r.state == AOF_ST_RUN && $rose(st_r.flag) && !st_r.wfmt) |->
      ((st_r.data == `AOF_ALL_ONES) || (st_r.data == `AOF_ALL_ZEROS));
  endproperty
  a_flag_word: assert property (p_flag_word) else $error("flag without extreme code"); // RL6
  property p_pd_zero;
    @(posedge clk_in) disable iff (sys_rst_in)
    (!st_r.pd_sync[1]) |=> ##1 (data_out == '0 && !out_of_range_flag);
  endproperty
  a_pd_zero: assert property (p_pd_zero) else $error("outputs not zero in power-down"); // RL10
  property p_oe;
    @(posedge clk_in) disable iff (sys_rst_in)
    st_r.oe_sync[1] |=> (data_oe_out == '0 && !flag_oe_out);
  endproperty
  a_oe: assert property (p_oe) else $error("data driven while disabled"); // RL2
  property p_sclk_oe;
    @(posedge clk_in) disable iff (sys_rst_in)
    st_r.ce_sync[1] |=> !sync_clock_oe_out;
  endproperty
  a_sclk_oe: assert property (p_sclk_oe) else $error("sync clock driven while off"); // RL9
  property p_edge_only_rise;
    @(posedge clk_in) disable iff (sys_rst_in)
    st_r.ck_edge |-> ($past(ck_lvl_w) && !$past(st_r.ck_prev));
  endproperty
  a_edge_only_rise: assert property (p_edge_only_rise) else $error("sample on wrong edge"); // RL1
  property p_update_on_edge;
    @(posedge clk_in) disable iff (sys_rst_in)
    (st_r.state == AOF_ST_RUN && $past(st_r.state) == AOF_ST_RUN && $changed(st_r.data))
      |-> $past(st_r.ck_edge);
  endproperty
  a_update_on_edge: assert property (p_update_on_edge) else $error("word moved off edge"); // RL12
  property p_pd_exit;
    @(posedge clk_in) disable iff (sys_rst_in)
    (st_r.state == AOF_ST_RUN && !st_r.pd_sync[1]) |=> (st_r.state == AOF_ST_OFF);
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("power-down not entered"); // RL10
  property p_clip;
    @(posedge clk_in) disable iff (sys_rst_in)
    (st_r.ck_edge && st_r.ovr_sync[1]) |-> fifo_wdata[DATA_W];
  endproperty
  a_clip: assert property (p_clip) else $error("over range not flagged"); // RL11
endmodule // aof_formatter

//--- aof_map.svh
// Constants for the ADC output formatter: codes, widths, pipeline figures.
// Assumes inclusion by the package and the formatter; definitions only.
// Summary of operation
// RL1 - Sample only on rising input clock edge
// RL2 - Output disable high tristates data outputs
// RL3 - Shorted inputs give mid-scale code 4096
// RL4 - Over range all ones, under range zeros
// RL5 - Clip and flag before extreme raw code
// RL6 - 13-bit flag set on all-ones or zeros
// RL7 - 12-bit receiver adds dropped LSB check
// RL8 - Format pin low offset binary, high twos
// RL9 - Sync clock driven only while enable low
// RL10 - Power-down low resets all digital outputs
// RL11 - Flag high when input out of range
// RL12 - Word and flag update together, fixed latency
`ifndef AOF_MAP_SVH
`define AOF_MAP_SVH
`define AOF_DATA_W      13
`define AOF_MID_CODE    13'h1000
`define AOF_ALL_ONES    13'h1fff
`define AOF_ALL_ZEROS   13'h0000
`define AOF_MSB         12
`define AOF_OFFSET_RST  13'h0000
`define AOF_CLIP_LO     13'h0001
`define AOF_CLIP_HI     13'h1ffe
`define AOF_FIFO_DEPTH  8
`endif

//--- aof_pkg.sv
// Types shared by the formatter files.
// Assumes aof_map.svh sits in the same folder.
`include "aof_map.svh"
package aof_pkg;
  typedef logic [`AOF_DATA_W-1:0] aof_word_t;   // One sample word
  typedef enum logic [1:0] {
    AOF_ST_OFF  = 2'b00,                         // Powered down
    AOF_ST_RUN  = 2'b01                          // Converting
  } aof_state_t;
endpackage

//--- aof_rx_model.sv
// Receiver model: takes the word and flag on each companion clock fall.
// Assumes resolved pin levels and the system clock for edge finding.
`timescale 1ns/10ps
module aof_rx_model
  import aof_pkg::*;
(
  input  wire logic      clk_in,      // Sampling clock
  input  wire logic      sync_clk_in, // Companion clock pin level
  input  wire aof_word_t word_in,     // Data pin levels
  input  wire logic      flag_in,     // Flag pin level
  input  wire logic      fmt_in,      // Format in use
  output aof_word_t      word_out,    // Captured word
  output logic           flag_out,    // Captured flag
  output logic           flag12_out,  // Flag as 12-bit use sees it
  output logic           strobe_out   // One cycle per capture
);
  logic      sync_d_r; // Last companion clock level
  aof_word_t w12;      // Word in offset binary
  assign w12 = word_in ^ {fmt_in, 12'h000};
  // Capture mid-word, far from the update edge
  always_ff @(posedge clk_in) begin
    sync_d_r <= sync_clk_in;
    strobe_out <= sync_d_r & ~sync_clk_in;
    if (sync_d_r & ~sync_clk_in) begin
      word_out <= word_in;
      flag_out <= flag_in;
      flag12_out <= (&w12[12:1] | ~|w12[12:1]) & (w12[1] == w12[0]);
    end
  end
endmodule // aof_rx_model

//--- test_aof_formatter.sv
// Bench: samples driven per sample clock, receiver captures, notes compared.
// Assumes the design files and the receiver model are compiled first.
`timescale 1ns/10ps
`include "aof_map.svh"
module test_aof_formatter
  import aof_pkg::*;
;
  typedef struct {int idx; logic [13:0] fw;} aof_note_t;
  logic      clk_in = 1'b0;       // System clock
  logic      clock_in_pos = 1'b0; // Sample clock, free running
  logic      sys_rst_in, raw_over_in, raw_under_in, format_select, power_down_low;
  logic      output_disable_in, sync_clock_enable_low, out_of_range_flag, flag_oe_out;
  logic      data_sync_clock_out, sync_clock_oe_out, rx_flag, rx_flag12, rx_strobe;
  logic      ovf_w;                  // Overflow pin
  logic [1:0] fmt_hist = 2'b00;      // Format at the last two sample rises
  aof_word_t raw_code_in, offset_trim_in, data_out, data_oe_out, rx_word, raw, trim;
  int        error_cnt = 0, samples_checked = 0, rise_cnt = 0, i, f;
  logic [15:0] r1 = 16'h9941, r2; // Random source
  aof_note_t note_q[$];           // Expected results, oldest first
  aof_note_t n;
  aof_word_t b_raw[9] = '{13'h1000, 13'h1ffd, 13'h1ffe, 13'h0002, 13'h0001,
                          13'h1000, 13'h0800, 13'h0800, 13'h0005};
  aof_word_t b_trim[9] = '{13'h0000, 13'h0000, 13'h0000, 13'h0000, 13'h0000,
                           13'h1fff, 13'h0000, 13'h0000, 13'h1ffd};
  always #2.5 clk_in = ~clk_in;
  initial #1.3 forever #32 clock_in_pos = ~clock_in_pos;
  always @(posedge clock_in_pos) begin
    rise_cnt++;
    fmt_hist <= {fmt_hist[0], format_select};
  end
  aof_formatter #(.DATA_W(`AOF_DATA_W), .DEPTH(`AOF_FIFO_DEPTH)) aof_formatter_inst (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .clock_in_pos(clock_in_pos),
    .clock_in_neg(1'b0), .raw_code_in(raw_code_in), .raw_over_in(raw_over_in),
    .raw_under_in(raw_under_in), .offset_trim_in(offset_trim_in),
    .format_select(format_select), .output_disable_in(output_disable_in),
    .sync_clock_enable_low(sync_clock_enable_low), .power_down_low(power_down_low),
    .data_out(data_out), .data_oe_out(data_oe_out), .out_of_range_flag(out_of_range_flag),
    .flag_oe_out(flag_oe_out), .data_sync_clock_out(data_sync_clock_out),
    .sync_clock_oe_out(sync_clock_oe_out), .overflow_out(ovf_w));
  // Released pins show the inverse of the driven level
  aof_rx_model aof_rx_model_inst (.clk_in(clk_in),
    .sync_clk_in(~(data_sync_clock_out ^ sync_clock_oe_out)),
    .word_in(~(data_out ^ data_oe_out)), .flag_in(~(out_of_range_flag ^ flag_oe_out)),
    .fmt_in(fmt_hist[1]), .word_out(rx_word), .flag_out(rx_flag),
    .flag12_out(rx_flag12), .strobe_out(rx_strobe));
  function automatic logic [15:0] lfsr_next(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Clamp, flag and format of one sample
  function automatic logic [13:0] expect_of(aof_word_t a, aof_word_t t, logic o, logic u,
                                            logic fm);
    aof_word_t s;
    logic      fl;
    s = a + t;
    fl = 1'b1;
    if (o || s >= 13'h1ffe) s = 13'h1fff;
    else if (u || s <= 13'h0001) s = 13'h0000;
    else fl = 1'b0;
    s[12] = s[12] ^ fm;
    return {fl, s};
  endfunction
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic bad(string m);
    error_cnt++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic chk_word(aof_word_t e, aof_word_t g);
    samples_checked++;
    if (g !== e) bad($sformatf("word exp %h got %h", e, g));
  endtask
  task automatic chk_bit(logic e, logic g);
    samples_checked++;
    if (g !== e) bad($sformatf("bit exp %b got %b", e, g));
  endtask
  // Bounded wait for a sample clock level
  task automatic wait_lvl(logic v);
    int k;
    for (k = 0; k < 40 && clock_in_pos !== v; k++) @(posedge clk_in);
    if (k == 40) begin
      bad("sample clock stuck");
      print_verdict();
    end
  endtask
  task automatic periods(int c);
    repeat (c) begin
      wait_lvl(1'b1);
      wait_lvl(1'b0);
    end
  endtask
  // Present one sample in the low half, note its result
  task automatic send(aof_word_t a, aof_word_t t, logic o, logic u, logic fm);
    periods(1);
    raw_code_in <= a;
    offset_trim_in <= t;
    raw_over_in <= o;
    raw_under_in <= u;
    format_select <= fm;
    note_q.push_back('{rise_cnt + 1, expect_of(a, t, o, u, fm)});
  endtask
  // Result of a sample shows after the following rise
  always @(posedge clk_in) begin
    if (rx_strobe === 1'b1) begin
      while (note_q.size() > 0 && note_q[0].idx < rise_cnt - 1) begin
        n = note_q.pop_front();
        bad("sample lost");
      end
      if (note_q.size() > 0 && note_q[0].idx == rise_cnt - 1) begin
        n = note_q.pop_front();
        chk_word(n.fw[12:0], rx_word);
        chk_bit(n.fw[13], rx_flag);
        chk_bit(n.fw[13], rx_flag12);
      end
    end
  end
  initial begin
    sys_rst_in = 1'b1;
    power_down_low = 1'b0;
    raw_code_in = 13'h1000;
    offset_trim_in = 13'h0000;
    {raw_over_in, raw_under_in, format_select, output_disable_in} = 4'h0;
    sync_clock_enable_low = 1'b0;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    power_down_low <= 1'b1;
    periods(4);
    for (f = 0; f < 2; f++)
      for (i = 0; i < 9; i++) send(b_raw[i], b_trim[i], i == 6, i == 7, f[0]);
    $display("test boundary done");
    for (i = 0; i < 40; i++) begin
      r1 = lfsr_next(r1);
      r2 = lfsr_next(r1);
      raw = r1[12:0];
      trim = (raw > 13'h0080 && raw < 13'h1f80) ? {{6{r2[7]}}, r2[6:0]} : 13'h0000;
      send(raw, trim, r2[15:13] == 3'h7, r2[15:13] == 3'h0, i[3]);
      r1 = r2;
    end
    send(13'h0400, 13'h0000, 1'b1, 1'b0, 1'b0);
    periods(3);
    chk_bit(1'b1, note_q.size() == 0);
    $display("test random done");
    output_disable_in <= 1'b1;
    sync_clock_enable_low <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk_word(13'h0000, data_oe_out);
    chk_bit(1'b0, flag_oe_out);
    chk_bit(1'b0, sync_clock_oe_out);
    output_disable_in <= 1'b0;
    sync_clock_enable_low <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk_word(13'h1fff, data_oe_out);
    chk_bit(1'b1, flag_oe_out);
    chk_bit(1'b1, sync_clock_oe_out);
    $display("test pins done");
    power_down_low <= 1'b0;
    repeat (8) @(posedge clk_in);
    for (i = 0; i < 16; i++) begin
      @(posedge clk_in);
      chk_word(13'h0000, data_out);
      chk_bit(1'b0, out_of_range_flag | data_sync_clock_out);
    end
    note_q.delete();
    power_down_low <= 1'b1;
    periods(4);
    for (i = 0; i < 4; i++) send(b_raw[i], b_trim[i], 1'b0, 1'b0, 1'b1);
    periods(3);
    chk_bit(1'b1, note_q.size() == 0);
    chk_bit(1'b0, ovf_w);
    $display("test power down done");
    print_verdict();
  end
endmodule // test_aof_formatter
